// [hw/oag_pkg.sv]
// Constants, mode codes and address arithmetic for the operand address generator.
// Assumes a single 8-bit data, 16-bit address memory bus shared by code and data.
// Behaviour
// - Inherent instructions are one byte; no extension bytes are fetched.
// - Immediate takes two bytes; the second byte is the operand, no memory access.
// - Short direct and short indirect reach page zero only, 0000h to 00FFh.
// - Long forms reach all 64 Kbyte but use more bytes and cycles.
// - Short direct: one address byte after opcode, operand at 00 to FF.
// - Long direct: two address bytes after opcode give a 16-bit address.
// - Indexed address is unsigned sum of chosen index register and offset.
// - Indexed without offset: no extra byte, address is index value alone.
// - Short indexed: one offset byte plus index, range 00 to 1FE.
// - Long indexed: two offset bytes plus index, anywhere in 64 Kbyte.
// - Indirect: byte after opcode is page-zero pointer address, pointer is read.
// - Short indirect: one-byte pointer is the operand address, 00 to FF.
// - Long indirect and long indirect-indexed read a 16-bit pointer word.
// - Indirect-indexed address is unsigned sum of index and fetched pointer.
// - Short indirect-indexed: byte pointer plus index, range 00 to 1FE.
// - Relative: signed 8-bit offset is added to the program counter.

package oag_pkg;

   localparam int          ADDR_W      = 16;
   localparam int          DATA_W      = 8;
   localparam logic [7:0]  PAGE_ZERO   = 8'h00;
   localparam logic [15:0] SHORT_MAX   = 16'h01FE;
   localparam logic [15:0] ADDR_RST    = 16'h0000;
   localparam logic [7:0]  BYTE_RST    = 8'h00;
   localparam logic [1:0]  LEN_NONE    = 2'h0;
   localparam logic [1:0]  LEN_BYTE    = 2'h1;
   localparam logic [1:0]  LEN_WORD    = 2'h2;

   typedef enum logic [3:0] {
      OAG_INH   = 4'h0,
      OAG_IMM   = 4'h1,
      OAG_DIR_S = 4'h2,
      OAG_DIR_L = 4'h3,
      OAG_IDX_0 = 4'h4,
      OAG_IDX_S = 4'h5,
      OAG_IDX_L = 4'h6,
      OAG_IND_S = 4'h7,
      OAG_IND_L = 4'h8,
      OAG_IIX_S = 4'h9,
      OAG_IIX_L = 4'hA,
      OAG_REL_D = 4'hB,
      OAG_REL_I = 4'hC
   } oag_mode_t;

   // Bytes that follow the opcode
   function automatic logic [1:0] oag_ext_len(input oag_mode_t m);
      case (m)
         OAG_IMM, OAG_DIR_S, OAG_IDX_S, OAG_IND_S, OAG_IND_L,
         OAG_IIX_S, OAG_IIX_L, OAG_REL_D, OAG_REL_I: oag_ext_len = LEN_BYTE;
         OAG_DIR_L, OAG_IDX_L:                      oag_ext_len = LEN_WORD;
         default:                                   oag_ext_len = LEN_NONE;
      endcase
   endfunction : oag_ext_len

   // Bytes of pointer read from page zero
   function automatic logic [1:0] oag_ptr_len(input oag_mode_t m);
      case (m)
         OAG_IND_S, OAG_IIX_S, OAG_REL_I: oag_ptr_len = LEN_BYTE;
         OAG_IND_L, OAG_IIX_L:            oag_ptr_len = LEN_WORD;
         default:                         oag_ptr_len = LEN_NONE;
      endcase
   endfunction : oag_ptr_len

   function automatic logic [15:0] oag_zext(input logic [7:0] b);
      oag_zext = {PAGE_ZERO, b};
   endfunction : oag_zext

   function automatic logic [15:0] oag_sext(input logic [7:0] b);
      oag_sext = {{8{b[7]}}, b};
   endfunction : oag_sext

   function automatic logic [15:0] oag_calc_ea(input oag_mode_t m, input logic [7:0] b1, input logic [7:0] b2,
                                               input logic [7:0] p1, input logic [7:0] p2,
                                               input logic [7:0] idx, input logic [15:0] npc);
      case (m)
         OAG_DIR_S: oag_calc_ea = oag_zext(b1);
         OAG_DIR_L: oag_calc_ea = {b1, b2};
         OAG_IDX_0: oag_calc_ea = oag_zext(idx);
         OAG_IDX_S: oag_calc_ea = oag_zext(b1) + oag_zext(idx);
         OAG_IDX_L: oag_calc_ea = {b1, b2} + oag_zext(idx);
         OAG_IND_S: oag_calc_ea = oag_zext(p1);
         OAG_IND_L: oag_calc_ea = {p1, p2};
         OAG_IIX_S: oag_calc_ea = oag_zext(p1) + oag_zext(idx);
         OAG_IIX_L: oag_calc_ea = {p1, p2} + oag_zext(idx);
         OAG_REL_D: oag_calc_ea = npc + oag_sext(b1);
         OAG_REL_I: oag_calc_ea = npc + oag_sext(p1);
         default:   oag_calc_ea = ADDR_RST;
      endcase
   endfunction : oag_calc_ea

endpackage : oag_pkg

// [hw/oag_fetch_if.sv]
// Byte-fetch request path between the address generator and its bus fetcher.
// Assumes both ends run on core_clk.
`timescale 1ns/10ps
interface oag_fetch_if;
   logic        req;
   logic [15:0] addr;
   logic        rdy;
   logic [7:0]  data;

   modport master (output req, output addr, input rdy, input data);
   modport slave  (input req, input addr, output rdy, output data);
endinterface : oag_fetch_if

// [hw/oag_fetch.sv]
// Single-byte reader on the shared memory bus.
// Assumes the memory answers with mem_ack on core_clk while mem_req stands.
`timescale 1ns/10ps
module oag_fetch (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   // Request from the generator
   oag_fetch_if.slave       fif,
   // Memory bus
   output logic             mem_req,
   output logic [15:0]      mem_addr,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        mem_ack
);

   logic       rdy_reg;
   logic [7:0] data_reg;

   assign fif.rdy  = rdy_reg;
   assign fif.data = data_reg;

   // Request stands until the memory acknowledges
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mem_req  <= 1'b0;
         mem_addr <= oag_pkg::ADDR_RST;
      end else if (clk_en) begin
         if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
         end else if (fif.req && !mem_req) begin
            mem_req  <= 1'b1;
            mem_addr <= fif.addr;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdy_reg  <= 1'b0;
         data_reg <= oag_pkg::BYTE_RST;
      end else if (clk_en) begin
         rdy_reg <= mem_req && mem_ack;
         if (mem_req && mem_ack) begin
            data_reg <= mem_rdata;
         end
      end
   end

endmodule : oag_fetch

// [hw/oag_addr_gen.sv]
// Operand address generator: counts extension bytes, reads page-zero pointers
// and forms the effective address. Assumes the caller gives the opcode address,
// the already selected index register value and the addressing mode.
`timescale 1ns/10ps
module oag_addr_gen #(
   parameter int ADDR_W = oag_pkg::ADDR_W,
   parameter int DATA_W = oag_pkg::DATA_W
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   // Decode request
   input  wire logic        start,
   input  wire logic [3:0]  mode,
   input  wire logic [15:0] opc_addr,
   input  wire logic [7:0]  index_val,
   output logic             ready,
   // Result
   output logic             done,
   output logic [15:0]      ea,
   output logic [7:0]       operand,
   output logic [15:0]      next_pc,
   output logic [1:0]       ext_count,
   // Memory bus
   output logic             mem_req,
   output logic [15:0]      mem_addr,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        mem_ack
);

   generate
      if (ADDR_W != 16 || DATA_W != 8) begin : g_chk
         $error("oag_addr_gen serves only 16-bit addresses and 8-bit data");
      end
   endgenerate

   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_EXT  = 4'b0010,
      S_PTR  = 4'b0100,
      S_CALC = 4'b1000
   } oag_state_t;

   oag_state_t          state_reg;
   oag_state_t          state_next;
   oag_pkg::oag_mode_t  mode_reg;
   logic [15:0]         pc_reg;
   logic [7:0]          idx_reg;
   logic [7:0]          b1_reg;
   logic [7:0]          b2_reg;
   logic [7:0]          p1_reg;
   logic [7:0]          p2_reg;
   logic [1:0]          cnt_reg;
   logic                pend_reg;
   logic [1:0]          nfetch_reg;
   logic [1:0]          ext_len;
   logic [1:0]          ptr_len;
   logic [15:0]         npc;

   oag_fetch_if fif ();

   oag_fetch u_fetch (
      .core_clk  (core_clk),
      .rst       (rst),
      .clk_en    (clk_en),
      .fif       (fif.slave),
      .mem_req   (mem_req),
      .mem_addr  (mem_addr),
      .mem_rdata (mem_rdata),
      .mem_ack   (mem_ack)
   );

   assign ext_len = oag_pkg::oag_ext_len(mode_reg);
   assign ptr_len = oag_pkg::oag_ptr_len(mode_reg);
   // Next instruction starts after opcode and its extension bytes
   assign npc     = pc_reg + 16'h0001 + {14'h0000, ext_len};
   assign ready   = (state_reg == S_IDLE);

   // One byte read at a time; a new request waits for the previous answer
   assign fif.req = ((state_reg == S_EXT) || (state_reg == S_PTR)) && !pend_reg;
   always_comb begin
      if (state_reg == S_PTR) begin
         fif.addr = oag_pkg::oag_zext(b1_reg) + {14'h0000, cnt_reg};
      end else begin
         fif.addr = pc_reg + 16'h0001 + {14'h0000, cnt_reg};
      end
   end

   // Sequencer
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         S_IDLE: begin
            if (start) begin
               if (oag_pkg::oag_ext_len(oag_pkg::oag_mode_t'(mode)) == oag_pkg::LEN_NONE) begin
                  state_next = S_CALC;
               end else begin
                  state_next = S_EXT;
               end
            end
         end
         S_EXT: begin
            if (fif.rdy && (cnt_reg + 2'h1 == ext_len)) begin
               if (ptr_len == oag_pkg::LEN_NONE) begin
                  state_next = S_CALC;
               end else begin
                  state_next = S_PTR;
               end
            end
         end
         S_PTR: begin
            if (fif.rdy && (cnt_reg + 2'h1 == ptr_len)) begin
               state_next = S_CALC;
            end
         end
         S_CALC: begin
            state_next = S_IDLE;
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_reg <= S_IDLE;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   // Request capture; unknown mode codes fall back to inherent
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mode_reg <= oag_pkg::OAG_INH;
         pc_reg   <= oag_pkg::ADDR_RST;
         idx_reg  <= oag_pkg::BYTE_RST;
      end else if (clk_en && ready && start) begin
         mode_reg <= (mode > 4'hC) ? oag_pkg::OAG_INH : oag_pkg::oag_mode_t'(mode);
         pc_reg   <= opc_addr;
         idx_reg  <= index_val;
      end
   end

   // Byte counter within a phase and outstanding-request flag
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_reg  <= 2'h0;
         pend_reg <= 1'b0;
      end else if (clk_en) begin
         if (state_reg != state_next) begin
            cnt_reg <= 2'h0;
         end else if (fif.rdy) begin
            cnt_reg <= cnt_reg + 2'h1;
         end
         if (fif.rdy) begin
            pend_reg <= 1'b0;
         end else if (fif.req) begin
            pend_reg <= 1'b1;
         end
      end
   end

   // Extension and pointer bytes, first byte is the high one
   always_ff @(posedge core_clk) begin
      if (rst) begin
         b1_reg <= oag_pkg::BYTE_RST;
         b2_reg <= oag_pkg::BYTE_RST;
         p1_reg <= oag_pkg::BYTE_RST;
         p2_reg <= oag_pkg::BYTE_RST;
      end else if (clk_en && fif.rdy) begin
         if (state_reg == S_EXT && cnt_reg == 2'h0) begin
            b1_reg <= fif.data;
         end
         if (state_reg == S_EXT && cnt_reg == 2'h1) begin
            b2_reg <= fif.data;
         end
         if (state_reg == S_PTR && cnt_reg == 2'h0) begin
            p1_reg <= fif.data;
         end
         if (state_reg == S_PTR && cnt_reg == 2'h1) begin
            p2_reg <= fif.data;
         end
      end
   end

   // Result, one-cycle done pulse
   always_ff @(posedge core_clk) begin
      if (rst) begin
         done      <= 1'b0;
         ea        <= oag_pkg::ADDR_RST;
         operand   <= oag_pkg::BYTE_RST;
         next_pc   <= oag_pkg::ADDR_RST;
         ext_count <= oag_pkg::LEN_NONE;
      end else if (clk_en) begin
         done <= (state_reg == S_CALC);
         if (state_reg == S_CALC) begin
            // Zero-extended 16-bit sums keep short indexed forms inside 1FE
            ea        <= oag_pkg::oag_calc_ea(mode_reg, b1_reg, b2_reg, p1_reg, p2_reg, idx_reg, npc);
            operand   <= (mode_reg == oag_pkg::OAG_IMM) ? b1_reg : oag_pkg::BYTE_RST;
            next_pc   <= npc;
            ext_count <= ext_len;
         end
      end
   end

   // Bytes read during the current instruction, watched by the checks below
   always_ff @(posedge core_clk) begin
      if (rst) begin
         nfetch_reg <= 2'h0;
      end else if (clk_en) begin
         if (ready && start) begin
            nfetch_reg <= 2'h0;
         end else if (fif.rdy) begin
            nfetch_reg <= nfetch_reg + 2'h1;
         end
      end
   end

   property p_inh;
      @(posedge core_clk) disable iff (rst)
      done && mode_reg == oag_pkg::OAG_INH |-> ext_count == 2'h0 && nfetch_reg == 2'h0 && next_pc == pc_reg + 16'h0001;
   endproperty
   a_inh: assert property (p_inh) else $error("inherent fetched extra bytes");

   property p_imm;
      @(posedge core_clk) disable iff (rst)
      done && mode_reg == oag_pkg::OAG_IMM |-> operand == b1_reg && nfetch_reg == 2'h1 && next_pc == pc_reg + 16'h0002;
   endproperty
   a_imm: assert property (p_imm) else $error("immediate operand or length wrong");

   property p_short_page;
      @(posedge core_clk) disable iff (rst)
      done && (mode_reg == oag_pkg::OAG_DIR_S || mode_reg == oag_pkg::OAG_IND_S) |-> ea[15:8] == 8'h00;
   endproperty
   a_short_page: assert property (p_short_page) else $error("short form left page zero");

   property p_long_len;
      @(posedge core_clk) disable iff (rst)
      done && (mode_reg == oag_pkg::OAG_DIR_L || mode_reg == oag_pkg::OAG_IDX_L) |-> nfetch_reg == 2'h2 && ext_count == 2'h2;
   endproperty
   a_long_len: assert property (p_long_len) else $error("long form length wrong");

   property p_dir_s;
      @(posedge core_clk) disable iff (rst)
      done && mode_reg == oag_pkg::OAG_DIR_S |-> ea == {8'h00, b1_reg} && nfetch_reg == 2'h1;
   endproperty
   a_dir_s: assert property (p_dir_s) else $error("short direct address wrong");

   property p_dir_l;
      @(posedge core_clk) disable iff (rst)
      done && mode_reg == oag_pkg::OAG_DIR_L |-> ea == {b1_reg, b2_reg};
   endproperty
   a_dir_l: assert property (p_dir_l) else $error("long direct address wrong");

   property p_idx_s;
      @(posedge core_clk) disable iff (rst)
      done && mode_reg == oag_pkg::OAG_IDX_S |-> ea == {8'h00, b1_reg} + {8'h00, idx_reg} && ea <= 16'h01FE;
   endproperty
   a_idx_s: assert property (p_idx_s) else $error("short indexed sum wrong");

   property p_idx_0;
      @(posedge core_clk) disable iff (rst)
      done && mode_reg == oag_pkg::OAG_IDX_0 |-> ea == {8'h00, idx_reg} && nfetch_reg == 2'h0;
   endproperty
   a_idx_0: assert property (p_idx_0) else $error("no-offset indexed wrong");

   property p_idx_l;
      @(posedge core_clk) disable iff (rst)
      done && mode_reg == oag_pkg::OAG_IDX_L |-> ea == {b1_reg, b2_reg} + {8'h00, idx_reg};
   endproperty
   a_idx_l: assert property (p_idx_l) else $error("long indexed sum wrong");

   property p_ptr_page;
      @(posedge core_clk) disable iff (rst)
      mem_req && state_reg == S_PTR |-> mem_addr[15:8] == 8'h00 || (mem_addr == 16'h0100 && b1_reg == 8'hFF);
   endproperty
   a_ptr_page: assert property (p_ptr_page) else $error("pointer read outside page zero");

   property p_ind_s;
      @(posedge core_clk) disable iff (rst)
      done && mode_reg == oag_pkg::OAG_IND_S |-> ea == {8'h00, p1_reg} && nfetch_reg == 2'h2;
   endproperty
   a_ind_s: assert property (p_ind_s) else $error("short indirect wrong");

   property p_long_ptr;
      @(posedge core_clk) disable iff (rst)
      done && (mode_reg == oag_pkg::OAG_IND_L || mode_reg == oag_pkg::OAG_IIX_L) |-> nfetch_reg == 2'h3;
   endproperty
   a_long_ptr: assert property (p_long_ptr) else $error("long pointer not a word");

   property p_iix;
      @(posedge core_clk) disable iff (rst)
      done && mode_reg == oag_pkg::OAG_IIX_L |-> ea == {p1_reg, p2_reg} + {8'h00, idx_reg};
   endproperty
   a_iix: assert property (p_iix) else $error("indirect indexed sum wrong");

   property p_iix_s;
      @(posedge core_clk) disable iff (rst)
      done && mode_reg == oag_pkg::OAG_IIX_S |-> ea == {8'h00, p1_reg} + {8'h00, idx_reg} && ea <= 16'h01FE;
   endproperty
   a_iix_s: assert property (p_iix_s) else $error("short indirect indexed wrong");

   property p_rel;
      @(posedge core_clk) disable iff (rst)
      done && mode_reg == oag_pkg::OAG_REL_D |-> ea == pc_reg + 16'h0002 + {{8{b1_reg[7]}}, b1_reg};
   endproperty
   a_rel: assert property (p_rel) else $error("relative target wrong");

   property p_ptr_order;
      @(posedge core_clk) disable iff (rst)
      $rose(mem_req) && state_reg == S_PTR && cnt_reg == 2'h1 |-> mem_addr == {8'h00, b1_reg} + 16'h0001;
   endproperty
   a_ptr_order: assert property (p_ptr_order) else $error("pointer low byte not at next address");

endmodule : oag_addr_gen

// [test/oag_mem_model.sv]
// Behavioural memory on the shared code and data bus of the address generator.
// Assumes the bench fills mem and sets wait_cyc before each transfer.
`timescale 1ns/10ps
module oag_mem_model (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // Memory bus
   input  wire logic        mem_req,
   input  wire logic [15:0] mem_addr,
   output logic [7:0]       mem_rdata,
   output logic             mem_ack,
   // Bench control
   input  wire logic [3:0]  wait_cyc,
   output logic [7:0]       rd_cnt
);
   logic [7:0] mem [0:65535];
   logic [3:0] cnt_reg;
   logic [7:0] last_reg;

   assign mem_ack   = mem_req && (cnt_reg == wait_cyc);
   // Between acknowledges the bus shows the inverse of the last byte, so a late sample never matches
   assign mem_rdata = mem_ack ? mem[mem_addr] : ~last_reg;

   always_ff @(posedge core_clk) begin
      if (rst || !mem_req) begin
         cnt_reg <= 4'h0;
      end else if (!mem_ack) begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         last_reg <= 8'h00;
         rd_cnt   <= 8'h00;
      end else if (mem_ack) begin
         last_reg <= mem[mem_addr];
         rd_cnt   <= rd_cnt + 8'h01;
      end
   end
endmodule : oag_mem_model

// [test/testbench.sv]
// Self-checking bench for the operand address generator and its memory model.
// Assumes one core_clk domain; memory contents are placed per case by the bench.
`timescale 1ns/10ps
module testbench;
   typedef struct {
      logic [3:0]  mode;
      logic [15:0] opc;
      logic [7:0]  idx, b1, b2, p1, p2;
      logic [15:0] ea;
      logic [7:0]  op;
      logic [1:0]  ext;
      logic [7:0]  rd;
   } oag_row_t;

   logic        core_clk, rst, clk_en, start, ready, done, mem_req, mem_ack;
   logic [3:0]  mode, wait_cyc;
   logic [15:0] opc_addr, ea, next_pc, mem_addr;
   logic [7:0]  index_val, operand, mem_rdata, rd_cnt, rd0;
   logic [1:0]  ext_count;
   int          error_cnt, n_tests, cyc_cnt, lat, lat_s, lat_l;

   oag_row_t rows [14] = '{
      '{4'h0, 16'h1000, 8'h33, 8'h11, 8'h22, 8'h44, 8'h55, 16'h0000, 8'h00, 2'h0, 8'h00},
      '{4'h1, 16'h1010, 8'h33, 8'hA5, 8'h22, 8'h44, 8'h55, 16'h0000, 8'hA5, 2'h1, 8'h01},
      '{4'h2, 16'h1020, 8'h33, 8'hFF, 8'h22, 8'h44, 8'h55, 16'h00FF, 8'h00, 2'h1, 8'h01},
      '{4'h3, 16'h1030, 8'h33, 8'hC3, 8'h21, 8'h44, 8'h55, 16'hC321, 8'h00, 2'h2, 8'h02},
      '{4'h4, 16'h1040, 8'hFF, 8'h11, 8'h22, 8'h44, 8'h55, 16'h00FF, 8'h00, 2'h0, 8'h00},
      '{4'h5, 16'h1050, 8'hFF, 8'hFF, 8'h22, 8'h44, 8'h55, 16'h01FE, 8'h00, 2'h1, 8'h01},
      '{4'h6, 16'h1060, 8'h20, 8'h12, 8'hF0, 8'h44, 8'h55, 16'h1310, 8'h00, 2'h2, 8'h02},
      '{4'h7, 16'h1070, 8'h33, 8'h40, 8'h22, 8'h7E, 8'h55, 16'h007E, 8'h00, 2'h1, 8'h02},
      '{4'h8, 16'h1080, 8'h33, 8'h50, 8'h22, 8'hAB, 8'hCD, 16'hABCD, 8'h00, 2'h1, 8'h03},
      '{4'h9, 16'h1090, 8'hFF, 8'h60, 8'h22, 8'hFF, 8'h55, 16'h01FE, 8'h00, 2'h1, 8'h02},
      '{4'hA, 16'h10A0, 8'h20, 8'h70, 8'h22, 8'h12, 8'hF0, 16'h1310, 8'h00, 2'h1, 8'h03},
      '{4'hB, 16'h1100, 8'h33, 8'h80, 8'h22, 8'h44, 8'h55, 16'h1082, 8'h00, 2'h1, 8'h01},
      '{4'hC, 16'h1200, 8'h33, 8'h90, 8'h22, 8'h7F, 8'h55, 16'h1281, 8'h00, 2'h1, 8'h02},
      '{4'hD, 16'h1300, 8'h33, 8'h11, 8'h22, 8'h44, 8'h55, 16'h0000, 8'h00, 2'h0, 8'h00}
   };

   oag_addr_gen oag_addr_gen_inst (
      .core_clk  (core_clk),
      .rst       (rst),
      .clk_en    (clk_en),
      .start     (start),
      .mode      (mode),
      .opc_addr  (opc_addr),
      .index_val (index_val),
      .ready     (ready),
      .done      (done),
      .ea        (ea),
      .operand   (operand),
      .next_pc   (next_pc),
      .ext_count (ext_count),
      .mem_req   (mem_req),
      .mem_addr  (mem_addr),
      .mem_rdata (mem_rdata),
      .mem_ack   (mem_ack)
   );

   oag_mem_model oag_mem_model_inst (
      .core_clk  (core_clk),
      .rst       (rst),
      .mem_req   (mem_req),
      .mem_addr  (mem_addr),
      .mem_rdata (mem_rdata),
      .mem_ack   (mem_ack),
      .wait_cyc  (wait_cyc),
      .rd_cnt    (rd_cnt)
   );

   always #2.5 core_clk = ~core_clk;

   task give_verdict;
      if (error_cnt == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict

   // Cuts a hang short well beyond the few hundred cycles the run needs
   always @(posedge core_clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         error_cnt++;
         give_verdict;
      end
   end

   task chk(input string name, input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Extension bytes follow the opcode; the pointer sits at the page-zero address in the first byte
   task load(input oag_row_t w);
      oag_mem_model_inst.mem[w.opc + 16'h0001] = w.b1;
      oag_mem_model_inst.mem[w.opc + 16'h0002] = w.b2;
      oag_mem_model_inst.mem[{8'h00, w.b1}] = w.p1;
      oag_mem_model_inst.mem[{8'h00, w.b1} + 16'h0001] = w.p2;
   endtask : load

   task issue(input oag_row_t w);
      load(w);
      rd0 = rd_cnt;
      @(posedge core_clk);
      start     <= 1'b1;
      mode      <= w.mode;
      opc_addr  <= w.opc;
      index_val <= w.idx;
      @(posedge core_clk);
      start <= 1'b0;
   endtask : issue

   task wait_done(output int n);
      n = 0;
      do begin
         @(posedge core_clk);
         #1 n++;
      end while (done !== 1'b1 && n < 100);
      chk("done", {15'h0000, done}, 16'h0001);
   endtask : wait_done

   task check_res(input oag_row_t w, input logic [7:0] base);
      chk("ea", ea, w.ea);
      chk("operand", {8'h00, operand}, {8'h00, w.op});
      chk("next_pc", next_pc, w.opc + 16'h0001 + {14'h0000, w.ext});
      chk("ext_count", {14'h0000, ext_count}, {14'h0000, w.ext});
      chk("reads", {8'h00, rd_cnt - base}, {8'h00, w.rd});
   endtask : check_res

   task run(input oag_row_t w, input logic frz, output int n);
      issue(w);
      if (frz) begin
         repeat (2) @(posedge core_clk);
         clk_en <= 1'b0;
         repeat (3) @(posedge core_clk);
         clk_en <= 1'b1;
      end
      wait_done(n);
      check_res(w, rd0);
   endtask : run

   initial begin
      core_clk  = 1'b0;
      rst       = 1'b1;
      clk_en    = 1'b1;
      start     = 1'b0;
      mode      = 4'h0;
      opc_addr  = 16'h0000;
      index_val = 8'h00;
      wait_cyc  = 4'h0;
      error_cnt = 0;
      n_tests   = 0;
      cyc_cnt   = 0;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      #1 chk("rst_ready", {15'h0000, ready}, 16'h0001);
      chk("rst_ctl", {12'h000, done, mem_req, ext_count}, 16'h0000);
      chk("rst_ea", ea, 16'h0000);
      chk("rst_pc", next_pc, 16'h0000);
      chk("rst_op", {8'h00, operand}, 16'h0000);
      for (int r = 0; r < 14; r++) begin
         wait_cyc = 4'(r % 3);
         run(rows[r], 1'b0, lat);
      end
      // Long forms cost more cycles than short ones on an idle bus
      wait_cyc = 4'h0;
      run(rows[2], 1'b0, lat_s);
      run(rows[3], 1'b0, lat_l);
      chk("long_slower", {15'h0000, lat_l > lat_s}, 16'h0001);
      // Start held high: ignored while busy, taken again in the done cycle
      wait_cyc = 4'h1;
      load(rows[8]);
      load(rows[2]);
      rd0 = rd_cnt;
      @(posedge core_clk);
      start     <= 1'b1;
      mode      <= rows[2].mode;
      opc_addr  <= rows[2].opc;
      index_val <= rows[2].idx;
      @(posedge core_clk);
      mode      <= rows[8].mode;
      opc_addr  <= rows[8].opc;
      index_val <= rows[8].idx;
      wait_done(lat);
      check_res(rows[2], rd0);
      @(posedge core_clk);
      start <= 1'b0;
      wait_done(lat);
      check_res(rows[8], rd0 + rows[2].rd);
      // Frozen clock enable during the slow first extension byte read of a long indirect-indexed form
      wait_cyc = 4'h8;
      run(rows[10], 1'b1, lat);
      // Reset in mid-transfer, then a clean recovery
      wait_cyc = 4'h4;
      issue(rows[9]);
      repeat (2) @(posedge core_clk);
      rst <= 1'b1;
      @(posedge core_clk);
      rst <= 1'b0;
      #1 chk("mid_rst", {13'h0000, ready, done, mem_req}, 16'h0004);
      chk("mid_rst_ea", ea, 16'h0000);
      run(rows[9], 1'b0, lat);
      give_verdict;
   end
endmodule : testbench
